// file: logic/omep_map.vh
// constants for the on-chip memory map and eprom programming block
`ifndef OMEP_MAP_VH
`define OMEP_MAP_VH
// ********************************************************************
// register word indices (byte address bits [4:2])
// ********************************************************************
`define OMEP_IDX_POS      3'h0
`define OMEP_IDX_CTL      3'h1
`define OMEP_IDX_DLY      3'h2
`define OMEP_IDX_PTR      3'h3
`define OMEP_IDX_UTIL     3'h4
// ********************************************************************
// field positions and reset values
// ********************************************************************
`define OMEP_POS_RAM_HI   7
`define OMEP_POS_RAM_LO   4
`define OMEP_POS_REG_HI   3
`define OMEP_POS_REG_LO   0
`define OMEP_POS_RST      8'h00
`define OMEP_CTL_DUAL     7
`define OMEP_CTL_LATCH    5
`define OMEP_CTL_EXCOL    4
`define OMEP_CTL_EXROW    3
`define OMEP_CTL_VOLT     0
`define OMEP_CTL_RST      8'h00
`define OMEP_UTIL_GO      0
// ********************************************************************
// address map
// ********************************************************************
`define OMEP_REG_BYTES    12'h080
`define OMEP_RAM_BYTES    12'h300
`define OMEP_RAM_SPILL    12'h380
`define OMEP_ROM_LOW      16'h2000
`define OMEP_ROM_HIGH     16'ha000
`define OMEP_UTIL_START   16'hbf00
`define OMEP_PTR_RST      16'ha000
`define OMEP_READY_CHAR   8'hff
// ********************************************************************
// operating modes, strap order {mode_pin_b_standby, mode_pin_a}
// ********************************************************************
`define OMEP_MODE_BOOT    2'b00
`define OMEP_MODE_TEST    2'b01
`define OMEP_MODE_SINGLE  2'b10
`define OMEP_MODE_EXPAND  2'b11
// ********************************************************************
// timing
// ********************************************************************
`define OMEP_INIT_WINDOW  7'd64
`define OMEP_CLK_NS       10
`define OMEP_EPROM_EMULATION_MODE_MIN_NS  2000000
`define OMEP_DLY_UNIT_NS  10000
`define OMEP_DLY_UNIT_CYC ((`OMEP_DLY_UNIT_NS + `OMEP_CLK_NS - 1) / `OMEP_CLK_NS)
`define OMEP_DLY_RST      (`OMEP_EPROM_EMULATION_MODE_MIN_NS / `OMEP_DLY_UNIT_NS)
`endif

// file: logic/omep_top.v
// memory map decoder, map position register and eprom programming control
`timescale 1ns/1ps
`include "omep_map.vh"

module omep_top (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata_ff,
  output reg         avs_waitrequest_ff,
  input  wire        mode_pin_a,
  input  wire        mode_pin_b_standby,
  input  wire [2:0]  porta_low_pins,
  input  wire        rom_high_placement,
  input  wire        rom_present,
  input  wire        eeprom_latch_enable,
  input  wire        vpp_high_detect,
  input  wire        cpu_valid,
  input  wire        cpu_write,
  input  wire [15:0] cpu_addr,
  input  wire [7:0]  cpu_wdata,
  input  wire [7:0]  rom_array_data,
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  input  wire        tx_ready,
  output reg         tx_valid_ff,
  output reg  [7:0]  tx_byte_ff,
  output reg         dec_reg_sel_ff,
  output reg         dec_ram_sel_ff,
  output reg  [9:0]  dec_ram_index_ff,
  output reg         dec_rom_sel_ff,
  output reg  [14:0] dec_rom_index_ff,
  output reg         rom_read_enable_ff,
  output reg  [14:0] eprom_emulation_mode_addr_ff,
  output reg  [7:0]  eprom_emulation_mode_data_ff,
  output reg         eprom_emulation_mode_dual_ff,
  output reg         vpp_gate_ff,
  output reg         eprom_emulation_mode_ff
);

  // ******************************************************************
  // utility states
  // ******************************************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SEND = 3'd1;
  localparam [2:0] ST_WAIT = 3'd2;
  localparam [2:0] ST_BURN = 3'd3;
  localparam [2:0] ST_ECHO = 3'd4;
  // counts are integers; cut them to the register widths on purpose
  localparam integer UNIT_LAST_I = `OMEP_DLY_UNIT_CYC - 1;
  localparam integer DLY_RST_I   = `OMEP_DLY_RST;
  localparam [9:0]   UNIT_LAST   = UNIT_LAST_I[9:0];
  localparam [15:0]  DLY_RST     = DLY_RST_I[15:0];

  // ******************************************************************
  // decode helpers
  // ******************************************************************
  // true when the address lies on the given 4-Kbyte page
  function page_hit;
    input [15:0] addr;
    input [3:0]  page;
    begin
      page_hit = (addr[15:12] == page);
    end
  endfunction

  // array index of a cpu address for the chosen rom base
  function [14:0] rom_index;
    input [15:0] addr;
    input        high;
    reg   [15:0] diff;
    begin
      diff = addr - (high ? `OMEP_ROM_HIGH : `OMEP_ROM_LOW);
      rom_index = diff[14:0];
    end
  endfunction

  // ******************************************************************
  // state
  // ******************************************************************
  reg  [1:0]  mode_ff;
  reg  [6:0]  win_cnt_ff;
  reg         lock_ff;
  reg  [7:0]  pos_ff;
  reg         dual_ff;
  reg         latch_ff;
  reg         excol_ff;
  reg         exrow_ff;
  reg         volt_ff;
  reg  [15:0] dly_reg_ff;
  reg  [15:0] ptr_reg_ff;
  reg  [2:0]  st_ff;
  reg  [9:0]  pre_ff;
  reg  [15:0] dly_cnt_ff;
  reg  [31:0] nxt_rdata;

  wire special  = (mode_ff == `OMEP_MODE_BOOT) | (mode_ff == `OMEP_MODE_TEST);
  wire window   = (win_cnt_ff < `OMEP_INIT_WINDOW);
  wire [2:0] idx = avs_address[4:2];
  wire commit   = (avs_read | avs_write) & ~avs_waitrequest_ff;
  wire wr_lo    = avs_write & commit & avs_byteenable[0];
  wire [3:0] ram_pg = pos_ff[`OMEP_POS_RAM_HI:`OMEP_POS_RAM_LO];
  wire [3:0] reg_pg = pos_ff[`OMEP_POS_REG_HI:`OMEP_POS_REG_LO];

  // map position write: once in the window in normal modes, free in special
  wire pos_wr = wr_lo & (idx == `OMEP_IDX_POS) & (special | (~lock_ff & window));
  wire ctl_wr = wr_lo & (idx == `OMEP_IDX_CTL);
  wire util_idle = (st_ff == ST_IDLE);
  wire go_wr  = wr_lo & (idx == `OMEP_IDX_UTIL) & avs_writedata[`OMEP_UTIL_GO];

  // eeprom latch overrides the eprom latch
  wire eff_latch = latch_ff & ~eeprom_latch_enable;

  // ******************************************************************
  // address decoder
  // ******************************************************************
  wire [11:0] off     = cpu_addr[11:0];
  wire        overlap = (ram_pg == reg_pg);
  wire        reg_hit = page_hit(cpu_addr, reg_pg) & (off < `OMEP_REG_BYTES);
  // hidden first 128 ram bytes move above the normal 768-byte span
  wire        ram_hit = page_hit(cpu_addr, ram_pg) &
                        (overlap ? ((off >= `OMEP_REG_BYTES) & (off < `OMEP_RAM_SPILL))
                                 : (off < `OMEP_RAM_BYTES));
  wire [11:0] spill   = off - `OMEP_RAM_BYTES;
  wire [9:0]  ram_idx = (overlap & (off >= `OMEP_RAM_BYTES)) ? spill[9:0] : off[9:0];
  // mode forcing of rom placement and presence
  wire rom_hi = (mode_ff == `OMEP_MODE_SINGLE) ? 1'b1 : rom_high_placement;
  wire rom_on = (mode_ff == `OMEP_MODE_TEST) ? 1'b0 :
                ((mode_ff == `OMEP_MODE_SINGLE) ? 1'b1 : rom_present);
  wire rom_hit = rom_on & (cpu_addr >= (rom_hi ? `OMEP_ROM_HIGH : `OMEP_ROM_LOW));
  // register block decodes first, then ram, then rom
  wire sel_reg = cpu_valid & reg_hit;
  wire sel_ram = cpu_valid & ~reg_hit & ram_hit;
  wire sel_rom = cpu_valid & ~reg_hit & ~ram_hit & rom_hit;
  wire [14:0] cpu_rom_idx = rom_index(cpu_addr, rom_hi);
  wire [14:0] ptr_rom_idx = rom_index(ptr_reg_ff, rom_hi);
  // dual-byte programming treats address bit 5 as don't care
  wire [14:0] cap_idx = dual_ff ? (cpu_rom_idx & 15'h7fdf) : cpu_rom_idx;
  wire [14:0] utl_idx = dual_ff ? (ptr_rom_idx & 15'h7fdf) : ptr_rom_idx;

  // ******************************************************************
  // mode straps, window counter and map position register
  // ******************************************************************
  // straps sampled while reset is held; the reset here is synchronous
  always @(posedge clock) begin
    if (sys_rst) begin
      mode_ff                 <= {mode_pin_b_standby, mode_pin_a};
      eprom_emulation_mode_ff <= ~mode_pin_a & ~mode_pin_b_standby &
                                 (porta_low_pins == 3'h0);
      win_cnt_ff              <= 7'd0;
      lock_ff                 <= 1'b0;
      pos_ff                  <= `OMEP_POS_RST;
    end else begin
      if (window)
        win_cnt_ff <= win_cnt_ff + 7'd1;
      // lock on first accepted write, or in normal modes when the window closes
      if (pos_wr | (~special & ~window))
        lock_ff <= 1'b1;
      if (pos_wr)
        pos_ff <= avs_writedata[7:0];
    end
  end

  // ******************************************************************
  // eprom programming control register
  // ******************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      dual_ff  <= 1'b0;
      latch_ff <= 1'b0;
      excol_ff <= 1'b0;
      exrow_ff <= 1'b0;
      volt_ff  <= 1'b0;
    end else if (ctl_wr) begin
      // latch frozen while voltage is on; cannot rise without high vpp
      if (~volt_ff)
        latch_ff <= avs_writedata[`OMEP_CTL_LATCH] & vpp_high_detect;
      // voltage enable only moves while the latch is already set
      if (latch_ff)
        volt_ff <= avs_writedata[`OMEP_CTL_VOLT];
      if (special) begin
        dual_ff  <= avs_writedata[`OMEP_CTL_DUAL];
        excol_ff <= avs_writedata[`OMEP_CTL_EXCOL];
        exrow_ff <= avs_writedata[`OMEP_CTL_EXROW];
      end
    end
  end

  // ******************************************************************
  // register bus slave: request seen, then answer one cycle later
  // ******************************************************************
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (idx)
      `OMEP_IDX_POS:  nxt_rdata[7:0] = pos_ff;
      `OMEP_IDX_CTL:  begin
        nxt_rdata[`OMEP_CTL_DUAL]  = dual_ff & special;
        nxt_rdata[`OMEP_CTL_LATCH] = latch_ff;
        nxt_rdata[`OMEP_CTL_EXCOL] = excol_ff & special;
        nxt_rdata[`OMEP_CTL_EXROW] = exrow_ff & special;
        nxt_rdata[`OMEP_CTL_VOLT]  = volt_ff;
      end
      `OMEP_IDX_DLY:  nxt_rdata[15:0] = dly_reg_ff;
      `OMEP_IDX_PTR:  nxt_rdata[15:0] = ptr_reg_ff;
      `OMEP_IDX_UTIL: nxt_rdata = {`OMEP_UTIL_START, 2'b00, eprom_emulation_mode_ff,
                                   vpp_high_detect, mode_ff, window, lock_ff,
                                   5'h00, st_ff};
      default:        nxt_rdata = 32'h0000_0000;
    endcase
  end

  // waitrequest high while idle; drops for the single answering cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff    <= 32'h0000_0000;
    end else if (commit) begin
      avs_waitrequest_ff <= 1'b1;
    end else if (avs_read | avs_write) begin
      avs_waitrequest_ff <= 1'b0;
      avs_readdata_ff    <= nxt_rdata;
    end
  end

  // ******************************************************************
  // resident programming utility
  // ******************************************************************
  // index registers are only writable while the utility is idle
  always @(posedge clock) begin
    if (sys_rst) begin
      dly_reg_ff <= DLY_RST;
      ptr_reg_ff <= `OMEP_PTR_RST;
    end else begin
      if (wr_lo & util_idle & (idx == `OMEP_IDX_DLY))
        dly_reg_ff <= avs_writedata[15:0];
      if (wr_lo & util_idle & (idx == `OMEP_IDX_PTR))
        ptr_reg_ff <= avs_writedata[15:0];
      else if ((st_ff == ST_ECHO) & tx_ready)
        ptr_reg_ff <= ptr_reg_ff + 16'h0001;
    end
  end

  // ready char, byte in, burn for the delay, verify byte out; only reset ends it
  always @(posedge clock) begin
    if (sys_rst) begin
      st_ff       <= ST_IDLE;
      tx_valid_ff <= 1'b0;
      tx_byte_ff  <= 8'h00;
      pre_ff      <= 10'd0;
      dly_cnt_ff  <= 16'h0000;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (go_wr & special) begin
            tx_valid_ff <= 1'b1;
            tx_byte_ff  <= `OMEP_READY_CHAR;
            st_ff       <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_ready) begin
            tx_valid_ff <= 1'b0;
            st_ff       <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (rx_valid) begin
            pre_ff     <= 10'd0;
            dly_cnt_ff <= dly_reg_ff;
            st_ff      <= ST_BURN;
          end
        end
        ST_BURN: begin
          // delay in units; a zero setting still burns one unit
          if (pre_ff == UNIT_LAST) begin
            pre_ff <= 10'd0;
            if (dly_cnt_ff <= 16'h0001) begin
              tx_valid_ff <= 1'b1;
              tx_byte_ff  <= rom_array_data;
              st_ff       <= ST_ECHO;
            end else begin
              dly_cnt_ff <= dly_cnt_ff - 16'h0001;
            end
          end else begin
            pre_ff <= pre_ff + 10'd1;
          end
        end
        ST_ECHO: begin
          if (tx_ready) begin
            tx_valid_ff <= 1'b0;
            st_ff       <= ST_WAIT;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ******************************************************************
  // registered decode outputs and programming latches
  // ******************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      dec_reg_sel_ff     <= 1'b0;
      dec_ram_sel_ff     <= 1'b0;
      dec_ram_index_ff   <= 10'h000;
      dec_rom_sel_ff     <= 1'b0;
      dec_rom_index_ff   <= 15'h0000;
      rom_read_enable_ff <= 1'b0;
      eprom_emulation_mode_addr_ff       <= 15'h0000;
      eprom_emulation_mode_data_ff       <= 8'h00;
      eprom_emulation_mode_dual_ff       <= 1'b0;
      vpp_gate_ff        <= 1'b0;
    end else begin
      dec_reg_sel_ff     <= sel_reg;
      dec_ram_sel_ff     <= sel_ram;
      dec_ram_index_ff   <= ram_idx;
      dec_rom_sel_ff     <= sel_rom;
      dec_rom_index_ff   <= cpu_rom_idx;
      // array reads are blocked while latched for programming
      rom_read_enable_ff <= sel_rom & ~cpu_write & ~eff_latch;
      eprom_emulation_mode_dual_ff       <= dual_ff;
      // utility takes precedence; it only runs in special modes
      if ((st_ff == ST_WAIT) & rx_valid) begin
        eprom_emulation_mode_addr_ff <= utl_idx;
        eprom_emulation_mode_data_ff <= rx_byte;
      end else if (sel_rom & cpu_write & eff_latch) begin
        eprom_emulation_mode_addr_ff <= cap_idx;
        eprom_emulation_mode_data_ff <= cpu_wdata;
      end
      vpp_gate_ff <= (volt_ff & eff_latch) |
                     ((st_ff == ST_BURN) & ~eeprom_latch_enable);
    end
  end

endmodule

// file: tb/omep_asserts.sv
// assertion checker for the memory map and eprom programming block
`timescale 1ns/1ps

module omep_asserts (
  input wire        clock,
  input wire        sys_rst,
  input wire        avs_waitrequest_ff,
  input wire        mode_pin_a,
  input wire        mode_pin_b_standby,
  input wire        eeprom_latch_enable,
  input wire        cpu_valid,
  input wire        cpu_write,
  input wire [15:0] cpu_addr,
  input wire        dec_reg_sel_ff,
  input wire        dec_ram_sel_ff,
  input wire [9:0]  dec_ram_index_ff,
  input wire        dec_rom_sel_ff,
  input wire        rom_read_enable_ff,
  input wire [14:0] eprom_emulation_mode_addr_ff,
  input wire        eprom_emulation_mode_dual_ff
);
  // straps as the block took them at the last reset edge
  reg [1:0] mode_ff;
  always @(posedge clock) begin
    if (sys_rst) begin
      mode_ff <= {mode_pin_b_standby, mode_pin_a};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ********************************************************************
  // decode and programming relations
  // ********************************************************************
  a_reg_wins: assert property (
    dec_reg_sel_ff |-> !dec_ram_sel_ff && !dec_rom_sel_ff) else $error("decode overlap");
  a_ram_bound: assert property (
    dec_ram_sel_ff |-> dec_ram_index_ff < 10'h300) else $error("ram index too big");
  a_test_no_rom: assert property (
    mode_ff == 2'h1 && cpu_valid |=> !dec_rom_sel_ff) else $error("rom seen in test mode");
  a_single_rom_high: assert property (
    mode_ff == 2'h2 && cpu_valid && cpu_addr < 16'ha000 |=> !dec_rom_sel_ff)
    else $error("rom below upper range in single chip");
  a_rom_floor: assert property (
    cpu_valid && cpu_addr < 16'h2000 |=> !dec_rom_sel_ff) else $error("rom below floor");
  a_eeprom_latch_enable_reads: assert property (
    cpu_valid && !cpu_write && eeprom_latch_enable |=> rom_read_enable_ff == dec_rom_sel_ff)
    else $error("eeprom latch did not cancel");
  a_write_no_read: assert property (
    cpu_valid && cpu_write |=> !rom_read_enable_ff) else $error("rom read on write");
  a_dual_bit5: assert property (
    eprom_emulation_mode_dual_ff && $changed(eprom_emulation_mode_addr_ff) |-> !eprom_emulation_mode_addr_ff[5]) else $error("bit 5 kept");
  a_wait_one: assert property (
    !avs_waitrequest_ff |=> avs_waitrequest_ff) else $error("waitrequest low too long");
endmodule

// file: tb/omep_host_model.sv
// serial host model that streams bytes to the resident programming utility
`timescale 1ns/1ps

module omep_host_model (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire       tx_valid_ff,
  input  wire [7:0] tx_byte_ff,
  input  wire [3:0] ready_lag,
  input  wire [7:0] first_byte,
  output reg        tx_ready,
  output reg        rx_valid,
  output reg  [7:0] rx_byte
);
  reg     [7:0] got [0:7];
  integer       n_got;

  initial begin
    tx_ready = 1'h0;
    rx_valid = 1'h0;
    rx_byte  = 8'h00;
    n_got    = 0;
  end

  // ********************************************************************
  // host side
  // ********************************************************************
  // stall before taking each byte, then send the next image byte
  always @(posedge clock) begin
    if (sys_rst) begin
      n_got = 0;
    end else if (tx_valid_ff && !tx_ready) begin
      repeat (ready_lag) @(posedge clock);
      tx_ready <= 1'h1;
      @(posedge clock);
      got[n_got] = tx_byte_ff;
      n_got = n_got + 1;
      tx_ready <= 1'h0;
      repeat (3) @(posedge clock);
      // two image bytes, starting at the first location
      if (n_got < 3) begin
        rx_valid <= 1'h1;
        rx_byte  <= first_byte + n_got[7:0] - 8'h01;
        @(posedge clock);
        rx_valid <= 1'h0;
        rx_byte  <= ~rx_byte; // idle line never shows stale data
      end
    end
  end
endmodule

// file: tb/omep_top_tb_top.sv
// self-checking bench for the memory map and eprom programming block
`timescale 1ns/1ps
`include "omep_map.vh"

bind omep_top omep_asserts chk (
  .clock(clock), .sys_rst(sys_rst), .avs_waitrequest_ff(avs_waitrequest_ff),
  .mode_pin_a(mode_pin_a), .mode_pin_b_standby(mode_pin_b_standby),
  .eeprom_latch_enable(eeprom_latch_enable), .cpu_valid(cpu_valid),
  .cpu_write(cpu_write), .cpu_addr(cpu_addr), .dec_reg_sel_ff(dec_reg_sel_ff),
  .dec_ram_sel_ff(dec_ram_sel_ff), .dec_ram_index_ff(dec_ram_index_ff),
  .dec_rom_sel_ff(dec_rom_sel_ff), .rom_read_enable_ff(rom_read_enable_ff),
  .eprom_emulation_mode_addr_ff(eprom_emulation_mode_addr_ff), .eprom_emulation_mode_dual_ff(eprom_emulation_mode_dual_ff));

module omep_top_tb_top;
  reg         clock, sys_rst, avs_read, avs_write, mode_pin_a, mode_pin_b_standby;
  reg         rom_high_placement, rom_present, eeprom_latch_enable, vpp_high_detect;
  reg         cpu_valid, cpu_write;
  reg  [4:0]  avs_address;
  reg  [31:0] avs_writedata, rd;
  reg  [2:0]  porta_low_pins;
  reg  [15:0] cpu_addr;
  reg  [7:0]  cpu_wdata, rom_array_data;
  wire [31:0] avs_readdata_ff;
  wire        avs_waitrequest_ff, rx_valid, tx_ready, tx_valid_ff, dec_reg_sel_ff;
  wire        dec_ram_sel_ff, dec_rom_sel_ff, rom_read_enable_ff, eprom_emulation_mode_dual_ff;
  wire        vpp_gate_ff, eprom_emulation_mode_ff;
  wire [7:0]  rx_byte, tx_byte_ff, eprom_emulation_mode_data_ff;
  wire [9:0]  dec_ram_index_ff;
  wire [14:0] dec_rom_index_ff, eprom_emulation_mode_addr_ff;
  integer     miscompares, n_compared, k;

  omep_top uut (
    .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata_ff(avs_readdata_ff), .avs_waitrequest_ff(avs_waitrequest_ff),
    .mode_pin_a(mode_pin_a), .mode_pin_b_standby(mode_pin_b_standby),
    .porta_low_pins(porta_low_pins), .rom_high_placement(rom_high_placement),
    .rom_present(rom_present), .eeprom_latch_enable(eeprom_latch_enable),
    .vpp_high_detect(vpp_high_detect), .cpu_valid(cpu_valid), .cpu_write(cpu_write),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .rom_array_data(rom_array_data),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid_ff(tx_valid_ff),
    .tx_byte_ff(tx_byte_ff), .dec_reg_sel_ff(dec_reg_sel_ff), .dec_ram_sel_ff(dec_ram_sel_ff),
    .dec_ram_index_ff(dec_ram_index_ff), .dec_rom_sel_ff(dec_rom_sel_ff),
    .dec_rom_index_ff(dec_rom_index_ff), .rom_read_enable_ff(rom_read_enable_ff),
    .eprom_emulation_mode_addr_ff(eprom_emulation_mode_addr_ff), .eprom_emulation_mode_data_ff(eprom_emulation_mode_data_ff), .eprom_emulation_mode_dual_ff(eprom_emulation_mode_dual_ff),
    .vpp_gate_ff(vpp_gate_ff), .eprom_emulation_mode_ff(eprom_emulation_mode_ff));

  omep_host_model host (
    .clock(clock), .sys_rst(sys_rst), .tx_valid_ff(tx_valid_ff), .tx_byte_ff(tx_byte_ff),
    .ready_lag(4'h2), .first_byte(8'h77), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_byte(rx_byte));

  // ********************************************************************
  // bus tasks and comparison
  // ********************************************************************
  task cmp(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task end_sim;
    begin
      if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  task do_reset(input [1:0] m, input [2:0] pa);
    begin
      sys_rst <= 1'h1;
      {mode_pin_b_standby, mode_pin_a} <= m;
      porta_low_pins <= pa;
      repeat (20) @(posedge clock);
      sys_rst <= 1'h0;
      @(posedge clock);
    end
  endtask

  // request stands until waitrequest is sampled low; a hang counts as a mismatch
  task avm(input wr, input [4:0] a, input [31:0] d);
    begin
      @(posedge clock);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      k = 0;
      @(posedge clock);
      while (avs_waitrequest_ff !== 1'h0 && k < 20) begin
        @(posedge clock);
        k = k + 1;
      end
      if (k == 20) miscompares = miscompares + 1;
      rd = avs_readdata_ff;
      avs_write <= 1'h0;
      avs_read  <= 1'h0;
    end
  endtask

  // read one register and compare it
  task rdc(input [4:0] a, input [31:0] exp);
    begin
      avm(1'h0, a, 32'h0);
      cmp("register", exp, rd);
    end
  endtask

  task wrd(input [4:0] a, input [31:0] d, input [31:0] exp);
    begin
      avm(1'h1, a, d);
      rdc(a, exp);
    end
  endtask

  // one cpu bus cycle; the decode is read in the cycle after it
  task cpu(input wr, input [15:0] a, input [7:0] d);
    begin
      @(posedge clock);
      cpu_valid <= 1'h1;
      cpu_write <= wr;
      cpu_addr  <= a;
      cpu_wdata <= d;
      @(posedge clock);
      cpu_valid <= 1'h0;
      @(posedge clock);
    end
  endtask

  task dchk(input [15:0] a, input [1:0] rm, input [9:0] mi, input o, input [14:0] oi);
    begin
      cpu(1'h0, a, 8'h00);
      cmp("decode", {4'h0, rm, mi, o, oi}, {4'h0, dec_reg_sel_ff, dec_ram_sel_ff,
          dec_ram_index_ff & {10{dec_ram_sel_ff}}, dec_rom_sel_ff,
          dec_rom_index_ff & {15{dec_rom_sel_ff}}});
    end
  endtask

  // ********************************************************************
  // clock, watchdog and tests
  // ********************************************************************
  always #5 clock = ~clock;

  initial begin
    repeat (20000) @(posedge clock);
    miscompares = miscompares + 1;
    end_sim;
  end

  initial begin
    clock = 1'h0;
    {avs_read, avs_write, cpu_valid, cpu_write} = 4'h0;
    {rom_high_placement, rom_present, eeprom_latch_enable, vpp_high_detect} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    rom_array_data = 8'hc3;
    miscompares = 0;
    n_compared = 0;
    // single chip: reset map, forced rom, write-once position
    do_reset(2'h2, 3'h7);
    rdc(5'h08, 32'hc8);
    rdc(5'h0c, {16'h0000, `OMEP_PTR_RST});
    dchk(16'h0000, 2'h2, 10'h000, 1'h0, 15'h0);
    dchk(16'h0080, 2'h1, 10'h080, 1'h0, 15'h0);
    dchk(16'h0300, 2'h1, 10'h000, 1'h0, 15'h0);
    dchk(16'h037f, 2'h1, 10'h07f, 1'h0, 15'h0);
    dchk(16'h2000, 2'h0, 10'h000, 1'h0, 15'h0);
    dchk(16'hffff, 2'h0, 10'h000, 1'h1, 15'h5fff);
    avm(1'h1, 5'h00, 32'h21);
    wrd(5'h00, 32'h43, 32'h21);
    dchk(16'h1000, 2'h2, 10'h000, 1'h0, 15'h0);
    dchk(16'h22ff, 2'h1, 10'h2ff, 1'h0, 15'h0);
    dchk(16'h2300, 2'h0, 10'h000, 1'h0, 15'h0);
    // normal mode after the 64-cycle window
    do_reset(2'h2, 3'h7);
    repeat (70) @(posedge clock);
    wrd(5'h00, 32'h21, 32'h00);
    // expanded: configuration decides placement and presence
    do_reset(2'h3, 3'h7);
    rom_present <= 1'h1;
    dchk(16'h2000, 2'h0, 10'h000, 1'h1, 15'h0);
    rom_high_placement <= 1'h1;
    dchk(16'h2000, 2'h0, 10'h000, 1'h0, 15'h0);
    dchk(16'ha000, 2'h0, 10'h000, 1'h1, 15'h0);
    // special test: rom removed, position writable late and often
    do_reset(2'h1, 3'h7);
    dchk(16'ha000, 2'h0, 10'h000, 1'h0, 15'h0);
    repeat (70) @(posedge clock);
    wrd(5'h00, 32'h10, 32'h10);
    wrd(5'h00, 32'h00, 32'h00);
    // bootstrap: manual programming sequence
    do_reset(2'h0, 3'h7);
    wrd(5'h04, 32'h20, 32'h00);
    vpp_high_detect <= 1'h1;
    wrd(5'h04, 32'h01, 32'h00);
    wrd(5'h04, 32'h66, 32'h20);
    cpu(1'h1, 16'ha123, 8'h5a);
    cmp("program addr", 32'h0123, {17'h00000, eprom_emulation_mode_addr_ff});
    cmp("program data", 32'h5a, {24'h000000, eprom_emulation_mode_data_ff});
    dchk(16'ha000, 2'h0, 10'h000, 1'h1, 15'h0);
    cmp("rom read", 32'h0, {31'h0, rom_read_enable_ff});
    wrd(5'h04, 32'h21, 32'h21);
    cmp("vpp gate", 32'h1, {31'h0, vpp_gate_ff});
    wrd(5'h04, 32'h00, 32'h20);
    cmp("vpp gate", 32'h0, {31'h0, vpp_gate_ff});
    wrd(5'h04, 32'ha0, 32'ha0);
    cpu(1'h1, 16'ha163, 8'h3c);
    cmp("program addr", 32'h8143, {16'h0000, eprom_emulation_mode_dual_ff, eprom_emulation_mode_addr_ff});
    eeprom_latch_enable <= 1'h1;
    cpu(1'h0, 16'ha000, 8'h00);
    cmp("rom read", 32'h1, {31'h0, rom_read_enable_ff});
    eeprom_latch_enable <= 1'h0;
    wrd(5'h04, 32'h00, 32'h00);
    wrd(5'h14, 32'hff, 32'h00);
    // resident utility: ready byte, two image bytes, verify echoes
    wrd(5'h08, 32'h1, 32'h1);
    avm(1'h1, 5'h10, 32'h1);
    k = 0;
    while (vpp_gate_ff !== 1'h1 && k < 3000) begin
      @(posedge clock);
      k = k + 1;
    end
    cmp("vpp gate", 32'h1, {31'h0, vpp_gate_ff});
    k = 0;
    while (host.n_got < 3 && k < 6000) begin
      @(posedge clock);
      k = k + 1;
    end
    cmp("host bytes", {8'h00, `OMEP_READY_CHAR, 16'hc3c3},
        {8'h00, host.got[0], host.got[1], host.got[2]});
    cmp("program addr", 32'h1, {17'h00000, eprom_emulation_mode_addr_ff});
    cmp("program data", 32'h78, {24'h000000, eprom_emulation_mode_data_ff});
    // emulation straps
    do_reset(2'h0, 3'h0);
    avm(1'h0, 5'h10, 32'h0);
    cmp("emulation", {`OMEP_UTIL_START, 16'h2001},
        {rd[31:16], 2'b00, rd[13], 12'h000, eprom_emulation_mode_ff});
    end_sim;
  end
endmodule
